// >>> hdl/sai_cfg.svh
// Constants for the stack and indirect addressing block
`ifndef SAI_CFG_SVH
`define SAI_CFG_SVH

// Stack
`define SAI_SP_EMPTY     5'h1F
`define SAI_SP_TOP       5'h0F
`define SAI_TOS_ZERO     15'h0000
`define SAI_TOS_LO_MSB   7
`define SAI_TOS_HI_LSB   8
`define SAI_TOS_MSB      14

// Pointer regions
`define SAI_TRAD_LAST    16'h0FFF
`define SAI_LIN_BASE     16'h2000
`define SAI_LIN_LAST     16'h29AF
`define SAI_RAM_SIZE     12'h050
`define SAI_RAM_BASE     7'h20
`define SAI_PORT0_OFS    7'h00
`define SAI_PORT1_OFS    7'h01
`define SAI_ZERO_BYTE    8'h00

// Register map, byte addresses
`define SAI_REG_CFG      8'h00
`define SAI_REG_SP       8'h04
`define SAI_REG_TOS_LO   8'h08
`define SAI_REG_TOS_HI   8'h0C
`define SAI_REG_FLAGS    8'h10
`define SAI_CFG_RST      1'b1
`define SAI_OVF_BIT      0
`define SAI_UNF_BIT      1
`define SAI_RESP_OKAY    2'h0
`define SAI_RESP_SLVERR  2'h2
`define SAI_ZERO_WORD    32'h0000_0000

`endif

// >>> hdl/sai_pkg.sv
// Types shared by the stack and indirect addressing block
package sai_pkg;

  typedef struct packed {
    logic [7:0] ptr_high;
    logic [7:0] ptr_low;
    logic       write;
    logic [7:0] wdata;
  } sai_ind_req_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        we;
    logic [7:0]  wdata;
  } sai_dmem_t;

  typedef enum logic [3:0] {
    SAI_REG_DATA   = 4'b0001,
    SAI_REG_SELF   = 4'b0010,
    SAI_REG_PROG   = 4'b0100,
    SAI_REG_UNIMPL = 4'b1000
  } sai_region_t;

  typedef enum logic [2:0] {
    SAI_IDLE   = 3'b001,
    SAI_ACCESS = 3'b010,
    SAI_EXTRA  = 3'b100
  } sai_ind_state_t;

endpackage

// >>> hdl/sai_stack.sv
// Sixteen-entry return stack with pointer, top-of-stack view and fault flags
`timescale 1ns/1ps
`include "sai_cfg.svh"

module sai_stack
  import sai_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Configuration
  input  wire logic        fault_en,
  // Core side
  input  wire logic        push,
  input  wire logic [14:0] push_pc,
  input  wire logic        pop,
  output logic      [14:0] ret_pc,
  output logic             fault_reset,
  // Software side
  input  wire logic        sw_sp_wr,
  input  wire logic [4:0]  sw_sp,
  input  wire logic        sw_lo_wr,
  input  wire logic        sw_hi_wr,
  input  wire logic [7:0]  sw_byte,
  input  wire logic        ovf_clr,
  input  wire logic        unf_clr,
  output logic      [4:0]  sp,
  output logic      [14:0] tos,
  output logic             ovf,
  output logic             unf
);

  logic [14:0] entry [16];
  logic [4:0]  next_sp;
  logic        is_ovf;
  logic        is_unf;
  logic        fault;

  assign next_sp = sp + 5'h01;
  assign is_ovf  = push && (sp >= `SAI_SP_TOP) && (sp != `SAI_SP_EMPTY);
  assign is_unf  = pop && !push && (sp == `SAI_SP_EMPTY);
  assign fault   = fault_en && (is_ovf || is_unf);
  // Empty pointer reads zero with fault reset on, else indexes entry 0x0F
  assign tos = (sp == `SAI_SP_EMPTY && fault_en) ? `SAI_TOS_ZERO : entry[sp[3:0]];

  // =========================================================
  // Pointer
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sp <= `SAI_SP_EMPTY;
    else if (fault)
      sp <= `SAI_SP_EMPTY;
    else if (push)
      sp <= next_sp;
    else if (pop)
      sp <= sp - 5'h01;
    else if (sw_sp_wr)
      sp <= sw_sp;
  end

  // =========================================================
  // Entries: push writes the slot the incremented pointer names
  for (genvar i = 0; i < 16; i++)
  begin : g_entry
    always_ff @(posedge ref_clk)
    begin
      if (rst)
        entry[i] <= `SAI_TOS_ZERO;
      else if (push && !fault && next_sp[3:0] == 4'(i))
        entry[i] <= push_pc;
      else if (!push && !pop && sw_lo_wr && sp[3:0] == 4'(i))
        entry[i][`SAI_TOS_LO_MSB:0] <= sw_byte;
      else if (!push && !pop && sw_hi_wr && sp[3:0] == 4'(i))
        entry[i][`SAI_TOS_MSB:`SAI_TOS_HI_LSB] <= sw_byte[6:0];
    end
  end

  // =========================================================
  // Return value, fault pulse and sticky flags
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ret_pc <= `SAI_TOS_ZERO;
    else if (pop && !push)
      ret_pc <= entry[sp[3:0]];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fault_reset <= 1'b0;
      ovf         <= 1'b0;
      unf         <= 1'b0;
    end
    else
    begin
      fault_reset <= fault;
      ovf         <= is_ovf || (ovf && !ovf_clr);
      unf         <= is_unf || (unf && !unf_clr);
    end
  end

  reset_empty_a: assert property (@(posedge ref_clk) rst |=> sp == `SAI_SP_EMPTY)
    else $error("stack not empty after reset");
  empty_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sp == `SAI_SP_EMPTY && fault_en) |-> tos == `SAI_TOS_ZERO)
    else $error("empty stack top not zero");
  wrap_push_a: assert property (@(posedge ref_clk) disable iff (rst)
    (push && !fault_en && sp == `SAI_SP_TOP) |=> (sp == 5'h10 && entry[0] == $past(push_pc)))
    else $error("seventeenth push did not overwrite first entry");
  ovf_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
    (is_ovf && fault_en) |=> (fault_reset && ovf && sp == `SAI_SP_EMPTY))
    else $error("overflow did not reset");
  unf_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    is_unf |=> unf ##1 (unf || $past(unf_clr)))
    else $error("underflow flag not set");
endmodule

// >>> hdl/sai_indirect.sv
// Indirect pointer decoder onto data memory, linear view and program memory
`timescale 1ns/1ps
`include "sai_cfg.svh"

module sai_indirect
  import sai_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Core side
  input  wire logic         req_valid,
  input  sai_ind_req_t      req,
  output logic              req_ready,
  output logic              done,
  output logic [7:0]        rdata,
  // Memories
  output sai_dmem_t         dmem,
  input  wire logic [7:0]   dmem_rdata,
  output logic [14:0]       pmem_addr,
  input  wire logic [13:0]  pmem_rdata
);

  sai_ind_state_t state;
  sai_region_t    region;
  sai_region_t    next_region;
  logic [15:0]    ptr;
  logic [15:0]    lin_ofs;
  logic [4:0]     lin_bank;
  logic [6:0]     lin_idx;
  logic [11:0]    next_addr;

  assign req_ready = (state == SAI_IDLE);

  // =========================================================
  // Region decode
  always_comb
  begin
    ptr         = {req.ptr_high, req.ptr_low};
    lin_ofs     = ptr - `SAI_LIN_BASE;
    lin_bank    = 5'(lin_ofs[11:0] / `SAI_RAM_SIZE);
    lin_idx     = 7'(lin_ofs[11:0] % `SAI_RAM_SIZE);
    next_region = SAI_REG_UNIMPL;
    next_addr   = ptr[11:0];
    if (ptr[15])
      next_region = SAI_REG_PROG;
    else if (ptr <= `SAI_TRAD_LAST)
    begin
      if (ptr[6:0] == `SAI_PORT0_OFS || ptr[6:0] == `SAI_PORT1_OFS)
        next_region = SAI_REG_SELF;
      else
        next_region = SAI_REG_DATA;
    end
    else if (ptr >= `SAI_LIN_BASE && ptr <= `SAI_LIN_LAST)
    begin
      next_region = SAI_REG_DATA;
      next_addr   = {lin_bank, 7'(`SAI_RAM_BASE + lin_idx)};
    end
  end

  // =========================================================
  // Access sequence
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state     <= SAI_IDLE;
      region    <= SAI_REG_UNIMPL;
      dmem      <= '0;
      pmem_addr <= '0;
      rdata     <= `SAI_ZERO_BYTE;
      done      <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        SAI_IDLE:
          if (req_valid)
          begin
            region     <= next_region;
            dmem.addr  <= next_addr;
            dmem.wdata <= req.wdata;
            dmem.we    <= req.write && next_region == SAI_REG_DATA;
            pmem_addr  <= ptr[14:0];
            state      <= SAI_ACCESS;
          end
        SAI_ACCESS:
        begin
          dmem.we <= 1'b0;
          if (region == SAI_REG_PROG)
            state <= SAI_EXTRA;
          else
          begin
            rdata <= (region == SAI_REG_DATA) ? dmem_rdata : `SAI_ZERO_BYTE;
            done  <= 1'b1;
            state <= SAI_IDLE;
          end
        end
        SAI_EXTRA:
        begin
          rdata <= pmem_rdata[7:0];
          done  <= 1'b1;
          state <= SAI_IDLE;
        end
        default:
          state <= SAI_IDLE;
      endcase
    end
  end

  prog_extra_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == SAI_ACCESS && region == SAI_REG_PROG) |=> (state == SAI_EXTRA && !done) ##1 done)
    else $error("program access not one cycle longer");
  no_bad_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    dmem.we |-> (region == SAI_REG_DATA && state == SAI_ACCESS))
    else $error("write outside data region");
  zero_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == SAI_ACCESS && region inside {SAI_REG_SELF, SAI_REG_UNIMPL})
      |=> (done && rdata == `SAI_ZERO_BYTE))
    else $error("port or unimplemented read not zero");
endmodule

// >>> hdl/sai_top.sv
// Stack and indirect addressing block with its register slave
`timescale 1ns/1ps
`include "sai_cfg.svh"

module sai_top
  import sai_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Core stack requests
  input  wire logic         push,
  input  wire logic [14:0]  push_pc,
  input  wire logic         pop,
  output logic      [14:0]  ret_pc,
  output logic              stack_fault_reset,
  // Core indirect requests
  input  wire logic         ind_valid,
  input  sai_ind_req_t      ind_req,
  output logic              ind_ready,
  output logic              ind_done,
  output logic [7:0]        ind_rdata,
  // Data and program memory
  output sai_dmem_t         dmem,
  input  wire logic [7:0]   dmem_rdata,
  output logic [14:0]       pmem_addr,
  input  wire logic [13:0]  pmem_rdata,
  // AXI4-Lite write channels
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready
);

  logic        stack_fault_reset_enable;
  logic [4:0]  stack_pointer_value;
  logic [14:0] tos;
  logic        stack_overflow_flag;
  logic        stack_underflow_flag;
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic        w_lane0;
  logic        wr_fire;
  logic        wr_hit;
  logic        sp_wr;
  logic        lo_wr;
  logic        hi_wr;
  logic        ovf_clr;
  logic        unf_clr;
  logic        cfg_wr;
  logic [31:0] next_rdata;
  logic        next_rerr;

  // =========================================================
  // Write channel capture: address and data in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      w_held  <= 1'b0;
      w_data  <= `SAI_ZERO_WORD;
      w_lane0 <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata;
      w_lane0 <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_held <= 1'b0;
  end

  // =========================================================
  // Write decode; every field lives in byte lane 0
  always_comb
  begin
    cfg_wr  = 1'b0;
    sp_wr   = 1'b0;
    lo_wr   = 1'b0;
    hi_wr   = 1'b0;
    ovf_clr = 1'b0;
    unf_clr = 1'b0;
    wr_hit  = 1'b1;
    if (aw_addr == `SAI_REG_CFG)
      cfg_wr = wr_fire && w_lane0;
    else if (aw_addr == `SAI_REG_SP)
      sp_wr = wr_fire && w_lane0;
    else if (aw_addr == `SAI_REG_TOS_LO)
      lo_wr = wr_fire && w_lane0;
    else if (aw_addr == `SAI_REG_TOS_HI)
      hi_wr = wr_fire && w_lane0;
    else if (aw_addr == `SAI_REG_FLAGS)
    begin
      ovf_clr = wr_fire && w_lane0 && w_data[`SAI_OVF_BIT];
      unf_clr = wr_fire && w_lane0 && w_data[`SAI_UNF_BIT];
    end
    else
      wr_hit = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SAI_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `SAI_RESP_OKAY : `SAI_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Fault reset is the option that steers the stack
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      stack_fault_reset_enable <= `SAI_CFG_RST;
    else if (cfg_wr)
      stack_fault_reset_enable <= w_data[0];
  end

  // =========================================================
  // Read channel; answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    next_rdata = `SAI_ZERO_WORD;
    next_rerr  = 1'b0;
    if (s_axi_araddr == `SAI_REG_CFG)
      next_rdata[0] = stack_fault_reset_enable;
    else if (s_axi_araddr == `SAI_REG_SP)
      next_rdata[4:0] = stack_pointer_value;
    else if (s_axi_araddr == `SAI_REG_TOS_LO)
      next_rdata[7:0] = tos[`SAI_TOS_LO_MSB:0];
    else if (s_axi_araddr == `SAI_REG_TOS_HI)
      next_rdata[6:0] = tos[`SAI_TOS_MSB:`SAI_TOS_HI_LSB];
    else if (s_axi_araddr == `SAI_REG_FLAGS)
    begin
      next_rdata[`SAI_OVF_BIT] = stack_overflow_flag;
      next_rdata[`SAI_UNF_BIT] = stack_underflow_flag;
    end
    else
      next_rerr = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `SAI_ZERO_WORD;
      s_axi_rresp  <= `SAI_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rerr ? `SAI_RESP_SLVERR : `SAI_RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // =========================================================
  // Stack and indirect decoder
  sai_stack u_stack (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .fault_en    (stack_fault_reset_enable),
    .push        (push),
    .push_pc     (push_pc),
    .pop         (pop),
    .ret_pc      (ret_pc),
    .fault_reset (stack_fault_reset),
    .sw_sp_wr    (sp_wr),
    .sw_sp       (w_data[4:0]),
    .sw_lo_wr    (lo_wr),
    .sw_hi_wr    (hi_wr),
    .sw_byte     (w_data[7:0]),
    .ovf_clr     (ovf_clr),
    .unf_clr     (unf_clr),
    .sp          (stack_pointer_value),
    .tos         (tos),
    .ovf         (stack_overflow_flag),
    .unf         (stack_underflow_flag)
  );

  sai_indirect u_indirect (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .req_valid  (ind_valid),
    .req        (ind_req),
    .req_ready  (ind_ready),
    .done       (ind_done),
    .rdata      (ind_rdata),
    .dmem       (dmem),
    .dmem_rdata (dmem_rdata),
    .pmem_addr  (pmem_addr),
    .pmem_rdata (pmem_rdata)
  );

  disabled_tos_a: assert property (@(posedge ref_clk) disable iff (rst)
    (stack_pointer_value == `SAI_SP_EMPTY && !stack_fault_reset_enable)
      |-> tos == u_stack.entry[15])
    else $error("empty stack top not entry 0x0F");
  unf_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
    (pop && !push && stack_pointer_value == `SAI_SP_EMPTY && stack_fault_reset_enable)
      |=> (stack_fault_reset && stack_underflow_flag))
    else $error("underflow did not reset");
  push_order_a: assert property (@(posedge ref_clk) disable iff (rst)
    (push && stack_pointer_value < `SAI_SP_TOP)
      |=> (stack_pointer_value == $past(stack_pointer_value) + 5'h01 && tos == $past(push_pc)))
    else $error("push did not increment then write");
  data_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ind_valid && ind_ready && !ind_req.ptr_high[7]) |=> !ind_done ##1 ind_done)
    else $error("data access not done in two cycles");
endmodule

// >>> verif/sai_mem_model.sv
// Behavioural data and program memories on the far side of the decoder
`timescale 1ns/1ps

module sai_mem_model
  import sai_pkg::*;
(
  // Clock
  input  wire logic        ref_clk,
  // Data memory
  input  sai_dmem_t        dmem,
  output logic      [7:0]  dmem_rdata,
  output logic      [15:0] wr_count,
  // Program memory
  input  wire logic [14:0] pmem_addr,
  output logic      [13:0] pmem_rdata
);
  // ==========================================
  // Storage
  // ==========================================
  logic [7:0]  mem [0:4095];
  logic [15:0] wr_cnt = 16'h0000;

  // Known pattern so every read has a predictable value
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = i[7:0] ^ 8'h3C;
  end

  // Counts writes so dropped writes are visible
  always @(posedge ref_clk)
  begin
    if (dmem.we)
    begin
      mem[dmem.addr] <= dmem.wdata;
      wr_cnt         <= wr_cnt + 16'h0001;
    end
  end

  assign wr_count = wr_cnt;

  assign dmem_rdata = mem[dmem.addr];
  // Read only: no write path exists at all
  assign pmem_rdata = pmem_addr[13:0] ^ 14'h2A5A;
endmodule

// >>> verif/tb_sai_top.sv
// Self-checking bench for the stack and indirect addressing block
`timescale 1ns/1ps
`include "sai_cfg.svh"

module tb_sai_top
  import sai_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         push = 1'b0;
  logic         pop = 1'b0;
  logic [14:0]  push_pc = 15'h0000;
  logic [14:0]  ret_pc;
  logic         stack_fault_reset;
  logic         ind_valid = 1'b0;
  sai_ind_req_t ind_req = '0;
  logic         ind_ready, ind_done;
  logic [7:0]   ind_rdata, dmem_rdata;
  sai_dmem_t    dmem;
  logic [14:0]  pmem_addr;
  logic [13:0]  pmem_rdata;
  logic [15:0]  wr_count, wc;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]  wdata = 32'h0000_0000, rdata, d;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic         arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid, f;
  logic [1:0]   bresp, rresp, r;
  logic [7:0]   q;
  int           lat, lat_d;
  int           num_errors = 0;
  int           n_tests = 0;

  always #20 ref_clk = ~ref_clk;

  sai_top sai_top_i (.ref_clk(ref_clk), .rst(rst), .push(push), .push_pc(push_pc),
    .pop(pop), .ret_pc(ret_pc), .stack_fault_reset(stack_fault_reset),
    .ind_valid(ind_valid), .ind_req(ind_req), .ind_ready(ind_ready), .ind_done(ind_done),
    .ind_rdata(ind_rdata), .dmem(dmem), .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr),
    .pmem_rdata(pmem_rdata), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  sai_mem_model sai_mem_model_i (.ref_clk(ref_clk), .dmem(dmem), .dmem_rdata(dmem_rdata),
    .wr_count(wr_count), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));

  // ==========================================
  // Checking and closing
  // ==========================================
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] dpat(input logic [11:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction

  // ==========================================
  // Register bus
  // ==========================================
  // Handshakes are judged at the falling edge, where ready has settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic t_aw, t_w, got;
    got = 1'b0;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 50 && !got; n++)
    begin
      @(negedge ref_clk);
      t_aw = awvalid & awready;
      t_w  = wvalid & wready;
      got  = bvalid;
      resp = bresp;
      @(posedge ref_clk);
      if (t_aw) awvalid <= 1'b0;
      if (t_w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    check("write answer", {31'h0, got}, 32'h1);
    if (!got) summarize();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic t_ar, got;
    got = 1'b0;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 50 && !got; n++)
    begin
      @(negedge ref_clk);
      t_ar = arvalid & arready;
      got  = rvalid;
      v    = rdata;
      resp = rresp;
      @(posedge ref_clk);
      if (t_ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check("read answer", {31'h0, got}, 32'h1);
    if (!got) summarize();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axi_wr(a, v, rs);
    check("write resp", {30'h0, rs}, {30'h0, `SAI_RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    logic [1:0]  rs;
    axi_rd(a, v, rs);
    check(what, v, exp);
  endtask

  task automatic tos_chk(input logic [14:0] exp, input string what);
    logic [31:0] lo, hi;
    logic [1:0]  rs;
    axi_rd(`SAI_REG_TOS_LO, lo, rs);
    axi_rd(`SAI_REG_TOS_HI, hi, rs);
    check(what, {17'h0, hi[6:0], lo[7:0]}, {17'h0, exp});
  endtask

  // ==========================================
  // Core side
  // ==========================================
  task automatic stk(input logic is_push, input logic [14:0] pc, output logic flt);
    @(posedge ref_clk);
    push    <= is_push;
    pop     <= !is_push;
    push_pc <= pc;
    @(posedge ref_clk);
    push <= 1'b0;
    pop  <= 1'b0;
    @(negedge ref_clk);
    flt = stack_fault_reset;
  endtask

  task automatic ind(input logic [15:0] p, input logic w, input logic [7:0] v,
                     output logic [7:0] rq, output int lt);
    logic took, dn;
    took = 1'b0;
    dn   = 1'b0;
    lt   = 0;
    @(posedge ref_clk);
    ind_valid <= 1'b1;
    ind_req   <= '{ptr_high: p[15:8], ptr_low: p[7:0], write: w, wdata: v};
    for (int n = 0; n < 50 && !took; n++)
    begin
      @(negedge ref_clk);
      took = ind_ready;
      @(posedge ref_clk);
    end
    ind_valid <= 1'b0;
    while (!dn && lt < 20)
    begin
      @(negedge ref_clk);
      lt++;
      dn = ind_done;
    end
    rq = ind_rdata;
    check("indirect done", {31'h0, dn}, 32'h1);
    if (!dn) summarize();
  endtask

  task automatic ind_chk(input logic [15:0] p, input logic [7:0] exp, input string what);
    logic [7:0] v;
    int         lt;
    ind(p, 1'b0, 8'h00, v, lt);
    check(what, {24'h0, v}, {24'h0, exp});
  endtask

  // ==========================================
  // Main sequence
  // ==========================================
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(`SAI_REG_SP, 32'h0000_001F, "sp after reset");
    tos_chk(15'h0000, "tos empty option on");
    wr(`SAI_REG_CFG, 32'h0000_0000);
    for (int i = 0; i < 16; i++)
      stk(1'b1, 15'h1000 + i[14:0], f);
    rd_chk(`SAI_REG_SP, 32'h0000_000F, "sp after sixteen pushes");
    stk(1'b1, 15'h7ABC, f);
    check("no fault reset option off", {31'h0, f}, 32'h0);
    rd_chk(`SAI_REG_FLAGS, 32'h0000_0001, "overflow flag option off");
    tos_chk(15'h7ABC, "wrapped push");
    wr(`SAI_REG_SP, 32'h0000_001F);
    tos_chk(15'h100F, "empty shows top entry");
    // Software writes land in the entry the pointer names
    wr(`SAI_REG_TOS_LO, 32'h0000_0034);
    wr(`SAI_REG_TOS_HI, 32'h0000_0012);
    tos_chk(15'h1234, "top entry written by software");
    wr(`SAI_REG_SP, 32'h0000_0001);
    stk(1'b0, 15'h0000, f);
    check("pop value", {17'h0, ret_pc}, 32'h0000_1001);
    rd_chk(`SAI_REG_SP, 32'h0000_0000, "sp after pop");
    stk(1'b1, 15'h0555, f);
    tos_chk(15'h0555, "push lands after increment");
    wr(`SAI_REG_FLAGS, 32'h0000_0003);
    wr(`SAI_REG_CFG, 32'h0000_0001);
    wr(`SAI_REG_SP, 32'h0000_001F);
    tos_chk(15'h0000, "empty reads zero");
    stk(1'b0, 15'h0000, f);
    check("underflow fault reset", {31'h0, f}, 32'h1);
    rd_chk(`SAI_REG_FLAGS, 32'h0000_0002, "underflow flag");
    wr(`SAI_REG_FLAGS, 32'h0000_0003);
    for (int i = 0; i < 17; i++)
    begin
      stk(1'b1, i[14:0], f);
      check("overflow fault reset", {31'h0, f}, {31'h0, i == 16});
    end
    rd_chk(`SAI_REG_FLAGS, 32'h0000_0001, "overflow flag");
    rd_chk(`SAI_REG_SP, 32'h0000_001F, "sp after fault reset");
    axi_rd(8'h14, d, r);
    check("unmapped read data", d, 32'h0000_0000);
    check("unmapped read resp", {30'h0, r}, {30'h0, `SAI_RESP_SLVERR});
    axi_wr(8'h14, 32'h0000_0001, r);
    check("unmapped write resp", {30'h0, r}, {30'h0, `SAI_RESP_SLVERR});
    ind(16'h0123, 1'b0, 8'h00, q, lat_d);
    check("traditional read", {24'h0, q}, {24'h0, dpat(12'h123)});
    ind_chk(16'h0880, 8'h00, "port zero read");
    ind_chk(16'h0001, 8'h00, "port one read");
    wc = wr_count;
    ind(16'h0001, 1'b1, 8'h77, q, lat);
    check("port write dropped", {16'h0, wr_count}, {16'h0, wc});
    ind(16'h2050, 1'b1, 8'hA5, q, lat);
    check("linear write", {16'h0, wr_count}, {16'h0, wc + 16'h0001});
    ind_chk(16'h00A0, 8'hA5, "linear second bank");
    ind_chk(16'h2000, dpat(12'h020), "linear skips common");
    ind_chk(16'h29AF, dpat(12'hF6F), "linear last");
    ind_chk(16'h29B0, 8'h00, "past linear");
    ind_chk(16'h1000, 8'h00, "unimplemented");
    ind(16'h8123, 1'b0, 8'h00, q, lat);
    check("program low byte", {24'h0, q}, 32'h0000_0079);
    check("program extra cycle", lat, lat_d + 1);
    ind_chk(16'hFFFF, 8'hA5, "program top");
    ind(16'h8123, 1'b1, 8'h00, q, lat);
    check("program write dropped", {16'h0, wr_count}, {16'h0, wc + 16'h0001});
    summarize();
  end
endmodule
